// ==== rtl/intctl_pkg.sv ====
// Constants for the core interrupt and option control block.
// Assumes a Wishbone classic master on one 20 MHz clock.
// Contract
// - Pull-up control bit 1 turns all port pull-ups off; 0 follows per-pin latches.
// - Edge select bit 1 flags rising external pin edge, 0 falling edge.
// - Source select 1 clocks timer from external pin, 0 from instruction clock.
// - With external clock, edge bit 1 counts falling, 0 counts rising transitions.
// - Assignment bit 1 routes prescaler to watchdog, 0 routes it to timer.
// - Timer prescale divides by two to the power of field plus one.
// - Watchdog prescale divides by two to the power of the field.
// - Global enable 1 passes unmasked interrupts, 0 blocks all.
// - Peripheral enable 1 passes peripheral interrupts, 0 blocks them.
// - Timer overflow enable gates whether the overflow flag interrupts.
// - External pin enable gates whether the external flag interrupts.
// - Port change interrupt needs its enable and per-pin change enables.
// - Overflow flag sets on timer rollover and stays until software clears.
// - Reset leaves the timer count unchanged.
// - External flag sets on the selected pin edge and holds until cleared.
// - Port change flag sets when any change-enabled pin of 5..0 changes; holds until cleared.
// - Flags set regardless of their own enable or the global enable.
package intctl_pkg;
	localparam logic [3:0] ADDR_OPTION    = 4'h0;
	localparam logic [3:0] ADDR_INTCTL    = 4'h4;
	localparam logic [3:0] ADDR_STATUS    = 4'h8;
	localparam logic [7:0] OPTION_RESET   = 8'hff;
	localparam logic [7:0] INTCTL_RESET   = 8'h00;
	localparam int         PORT_WIDTH     = 6;
	// Option bit positions
	localparam int B_PULLUP_OFF  = 7;
	localparam int B_EDGE_SEL    = 6;
	localparam int B_CLK_SRC     = 5;
	localparam int B_EXT_EDGE    = 4;
	localparam int B_PS_ASSIGN   = 3;
	localparam int B_PS_RATE_HI  = 2;
	// Interrupt control bit positions
	localparam int B_GIE         = 7;
	localparam int B_PERIPH_IRQ_ENABLE        = 6;
	localparam int B_TMR_OVERFLOW_IRQ_ENABLE        = 5;
	localparam int B_EXTIE       = 4;
	localparam int B_PCIE        = 3;
	localparam int B_TOF         = 2;
	localparam int B_EXTF        = 1;
	localparam int B_PCF         = 0;
endpackage

// ==== rtl/core_interrupt_option_control.sv ====
// Option and interrupt control registers with flag capture and request logic.
// Assumes synchronous pin inputs and a Wishbone classic master.
//
// The placing of the registers and register access over Wishbone were decided locally.
`timescale 1ns/1ps
module core_interrupt_option_control
	import intctl_pkg::*;
#(
	parameter int PORT_W = PORT_WIDTH
)(
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              rstn,
	input  wire logic              clk_en,
	// Wishbone slave
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [3:0]        wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	output logic                   wb_err_o,
	// Pins and event sources
	input  wire logic              ext_irq_pin,
	input  wire logic              tmr_ext_clk_pin,
	input  wire logic [PORT_W-1:0] port_a_a,
	input  wire logic [PORT_W-1:0] pin_change_enable_reg,
	input  wire logic [PORT_W-1:0] pullup_latch,
	input  wire logic              tmr_rollover,
	input  wire logic              periph_pending,
	// Control outputs
	output logic [PORT_W-1:0]      pullup_en,
	output logic                   tmr_tick,
	output logic                   prescaler_to_wdt,
	output logic [8:0]             prescale_div,
	output logic                   core_irq
);
	// Refuse port widths that the change detector cannot serve
	if (PORT_W < 1 || PORT_W > 8)
	begin : g_bad_width
		$error("PORT_W out of range");
	end

	typedef struct packed {
		logic [7:0]        option_config;
		logic [7:0]        interrupt_control;
		logic              ext_pin_d;
		logic              tclk_d;
		logic [PORT_W-1:0] port_d;
		logic              primed;
		logic              ack;
		logic [31:0]       dat;
	} state_type;

	state_type s_r, s_nxt;

	// Option fields
	logic       pullup_disable_all;
	logic       ext_irq_edge_sel;
	logic       tmr_clk_source_sel;
	logic       tmr_ext_edge_sel;
	logic       prescaler_assign;
	logic [2:0] prescaler_rate;
	// Events and bus qualifiers
	logic       ext_edge_hit;
	logic       tclk_edge_hit;
	logic       port_change_hit;
	logic       access;
	logic       bus_write;

	assign pullup_disable_all = s_r.option_config[B_PULLUP_OFF];
	assign ext_irq_edge_sel   = s_r.option_config[B_EDGE_SEL];
	assign tmr_clk_source_sel = s_r.option_config[B_CLK_SRC];
	assign tmr_ext_edge_sel   = s_r.option_config[B_EXT_EDGE];
	assign prescaler_assign   = s_r.option_config[B_PS_ASSIGN];
	assign prescaler_rate     = s_r.option_config[B_PS_RATE_HI:0];

	// ****************************************
	// Event detection
	// ****************************************
	assign ext_edge_hit = s_r.primed && (ext_irq_edge_sel ? (ext_irq_pin && !s_r.ext_pin_d)
		: (!ext_irq_pin && s_r.ext_pin_d));
	assign tclk_edge_hit = s_r.primed && (tmr_ext_edge_sel ? (!tmr_ext_clk_pin && s_r.tclk_d)
		: (tmr_ext_clk_pin && !s_r.tclk_d));
	// Only pins enabled for change detection may raise the change flag
	assign port_change_hit = s_r.primed
		&& (|((port_a_a ^ s_r.port_d) & pin_change_enable_reg));

	// ****************************************
	// Option decode
	// ****************************************
	always_comb
	begin
		pullup_en = pullup_disable_all ? '0 : pullup_latch;
		tmr_tick = tmr_clk_source_sel ? tclk_edge_hit : 1'b1;
		prescaler_to_wdt = prescaler_assign;
		if (prescaler_assign)
			prescale_div = 9'(1) << prescaler_rate;
		else
			prescale_div = 9'(2) << prescaler_rate;
	end

	// ****************************************
	// Interrupt request
	// ****************************************
	always_comb
	begin
		core_irq = s_r.interrupt_control[B_GIE] && (
			(s_r.interrupt_control[B_TMR_OVERFLOW_IRQ_ENABLE] && s_r.interrupt_control[B_TOF]) ||
			(s_r.interrupt_control[B_EXTIE] && s_r.interrupt_control[B_EXTF]) ||
			(s_r.interrupt_control[B_PCIE] && s_r.interrupt_control[B_PCF]) ||
			(s_r.interrupt_control[B_PERIPH_IRQ_ENABLE] && periph_pending));
	end

	// ****************************************
	// Register bus and next state
	// ****************************************
	assign access    = wb_cyc_i && wb_stb_i && !s_r.ack;
	assign bus_write = access && wb_we_i && wb_sel_i[0];

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.ack = access;
		s_nxt.ext_pin_d = ext_irq_pin;
		s_nxt.tclk_d = tmr_ext_clk_pin;
		s_nxt.port_d = port_a_a;
		s_nxt.primed = 1'b1;
		if (access && !wb_we_i)
		begin
			case (wb_adr_i)
				ADDR_OPTION: s_nxt.dat = {24'h0, s_r.option_config};
				ADDR_INTCTL: s_nxt.dat = {24'h0, s_r.interrupt_control};
				ADDR_STATUS: s_nxt.dat = {31'h0, core_irq};
				default:     s_nxt.dat = 32'h0;
			endcase
		end
		if (bus_write && wb_adr_i == ADDR_OPTION)
			s_nxt.option_config = wb_dat_i[7:0];
		if (bus_write && wb_adr_i == ADDR_INTCTL)
			s_nxt.interrupt_control = wb_dat_i[7:0];
		// Hardware set wins over a software clear in the same cycle
		if (tmr_rollover)
			s_nxt.interrupt_control[B_TOF] = 1'b1;
		if (ext_edge_hit)
			s_nxt.interrupt_control[B_EXTF] = 1'b1;
		if (port_change_hit && (|(port_a_a ^ s_r.port_d)))
			s_nxt.interrupt_control[B_PCF] = 1'b1;
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			// Timer count lives outside; reset here touches no count
			s_r <= '0;
			s_r.option_config <= OPTION_RESET;
			s_r.interrupt_control <= INTCTL_RESET;
		end
		else if (clk_en)
			s_r <= s_nxt;
	end

	assign wb_ack_o = s_r.ack;
	assign wb_dat_o = s_r.dat;
	assign wb_err_o = 1'b0;

	// ****************************************
	// Checks
	// ****************************************
	a_pullup_off: assert property (@(posedge clock) disable iff (!rstn)
		pullup_disable_all |-> pullup_en == '0) else $error("pull-ups not off");
	a_wdt_div: assert property (@(posedge clock) disable iff (!rstn)
		prescaler_assign |-> prescale_div == (9'(1) << prescaler_rate)) else $error("wdt ratio wrong");
	a_tmr_div: assert property (@(posedge clock) disable iff (!rstn)
		!prescaler_assign |-> prescale_div == (9'(2) << prescaler_rate)) else $error("timer ratio wrong");
	a_tof_set: assert property (@(posedge clock) disable iff (!rstn)
		clk_en && tmr_rollover |=> s_r.interrupt_control[B_TOF]) else $error("overflow flag not set");
	a_extf_set: assert property (@(posedge clock) disable iff (!rstn)
		clk_en && ext_edge_hit |=> s_r.interrupt_control[B_EXTF]) else $error("ext flag not set");
	a_pcf_set: assert property (@(posedge clock) disable iff (!rstn)
		clk_en && port_change_hit |=> s_r.interrupt_control[B_PCF]) else $error("change flag not set");
	a_gie_block: assert property (@(posedge clock) disable iff (!rstn)
		!s_r.interrupt_control[B_GIE] |-> !core_irq) else $error("irq with global off");
	a_periph_pass: assert property (@(posedge clock) disable iff (!rstn)
		s_r.interrupt_control[B_GIE] && s_r.interrupt_control[B_PERIPH_IRQ_ENABLE] && periph_pending |-> core_irq)
		else $error("peripheral irq lost");
	a_ack_pulse: assert property (@(posedge clock) disable iff (!rstn)
		wb_ack_o && clk_en |=> !wb_ack_o) else $error("ack held");

	// ****************************************
	// Option checks
	// ****************************************
	a_pullup_follow: assert property (@(posedge clock) disable iff (!rstn)
		!pullup_disable_all |-> pullup_en == pullup_latch)
		else $error("pull-ups ignore latches");

	a_edge_rise: assert property (@(posedge clock) disable iff (!rstn)
		ext_edge_hit && ext_irq_edge_sel |-> ext_irq_pin && !s_r.ext_pin_d)
		else $error("rising edge flag on wrong level");

	a_edge_fall: assert property (@(posedge clock) disable iff (!rstn)
		ext_edge_hit && !ext_irq_edge_sel |-> !ext_irq_pin && s_r.ext_pin_d)
		else $error("falling edge flag on wrong level");

	a_tick_internal: assert property (@(posedge clock) disable iff (!rstn)
		!tmr_clk_source_sel |-> tmr_tick)
		else $error("internal tick missing");

	a_tick_external: assert property (@(posedge clock) disable iff (!rstn)
		tmr_clk_source_sel |-> tmr_tick == tclk_edge_hit)
		else $error("external tick wrong");

	a_tick_fall: assert property (@(posedge clock) disable iff (!rstn)
		tmr_clk_source_sel && tmr_ext_edge_sel && tmr_tick |-> !tmr_ext_clk_pin && s_r.tclk_d)
		else $error("tick not on falling edge");

	a_tick_rise: assert property (@(posedge clock) disable iff (!rstn)
		tmr_clk_source_sel && !tmr_ext_edge_sel && tmr_tick |-> tmr_ext_clk_pin && !s_r.tclk_d)
		else $error("tick not on rising edge");

	a_psa_route: assert property (@(posedge clock) disable iff (!rstn)
		prescaler_to_wdt == prescaler_assign)
		else $error("prescaler routed wrongly");

	a_div_onehot: assert property (@(posedge clock) disable iff (!rstn)
		$onehot(prescale_div))
		else $error("ratio not a power of two");

	a_tmr_no_unity: assert property (@(posedge clock) disable iff (!rstn)
		!prescaler_assign |-> prescale_div != 9'h001)
		else $error("timer ratio one while assigned");

	// ****************************************
	// Request checks
	// ****************************************
	a_tof_pass: assert property (@(posedge clock) disable iff (!rstn)
		s_r.interrupt_control[B_GIE] && s_r.interrupt_control[B_TMR_OVERFLOW_IRQ_ENABLE] && s_r.interrupt_control[B_TOF] |-> core_irq)
		else $error("overflow irq lost");

	a_extf_pass: assert property (@(posedge clock) disable iff (!rstn)
		s_r.interrupt_control[B_GIE] && s_r.interrupt_control[B_EXTIE] && s_r.interrupt_control[B_EXTF] |-> core_irq)
		else $error("ext irq lost");

	a_pcf_pass: assert property (@(posedge clock) disable iff (!rstn)
		s_r.interrupt_control[B_GIE] && s_r.interrupt_control[B_PCIE] && s_r.interrupt_control[B_PCF] |-> core_irq)
		else $error("change irq lost");

	a_irq_cause: assert property (@(posedge clock) disable iff (!rstn)
		core_irq |-> (s_r.interrupt_control[B_TMR_OVERFLOW_IRQ_ENABLE] && s_r.interrupt_control[B_TOF])
			|| (s_r.interrupt_control[B_EXTIE] && s_r.interrupt_control[B_EXTF])
			|| (s_r.interrupt_control[B_PCIE] && s_r.interrupt_control[B_PCF])
			|| (s_r.interrupt_control[B_PERIPH_IRQ_ENABLE] && periph_pending))
		else $error("irq without cause");

	// ****************************************
	// Flag checks
	// ****************************************
	a_tof_hold: assert property (@(posedge clock) disable iff (!rstn)
		clk_en && s_r.interrupt_control[B_TOF] && !(bus_write && wb_adr_i == ADDR_INTCTL)
		|=> s_r.interrupt_control[B_TOF])
		else $error("overflow flag lost");

	a_extf_hold: assert property (@(posedge clock) disable iff (!rstn)
		clk_en && s_r.interrupt_control[B_EXTF] && !(bus_write && wb_adr_i == ADDR_INTCTL)
		|=> s_r.interrupt_control[B_EXTF])
		else $error("ext flag lost");

	a_pcf_hold: assert property (@(posedge clock) disable iff (!rstn)
		clk_en && s_r.interrupt_control[B_PCF] && !(bus_write && wb_adr_i == ADDR_INTCTL)
		|=> s_r.interrupt_control[B_PCF])
		else $error("change flag lost");

	a_flag_unmasked: assert property (@(posedge clock) disable iff (!rstn)
		clk_en && ext_edge_hit && !s_r.interrupt_control[B_EXTIE] |=> s_r.interrupt_control[B_EXTF])
		else $error("masked ext flag not set");

	a_no_false_edge: assert property (@(posedge clock) disable iff (!rstn)
		!s_r.primed |-> !ext_edge_hit && !tclk_edge_hit && !port_change_hit)
		else $error("edge before detectors armed");

	// ****************************************
	// Bus and enable checks
	// ****************************************
	a_freeze: assert property (@(posedge clock) disable iff (!rstn)
		!clk_en |=> $stable(s_r))
		else $error("state moved while frozen");

	a_ack_follows: assert property (@(posedge clock) disable iff (!rstn)
		clk_en && access |=> wb_ack_o)
		else $error("ack missing");

	a_ack_idle: assert property (@(posedge clock) disable iff (!rstn)
		clk_en && !access |=> !wb_ack_o)
		else $error("ack without request");

	a_dat_upper: assert property (@(posedge clock) disable iff (!rstn)
		wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("upper read bits set");

	a_err_low: assert property (@(posedge clock) disable iff (!rstn)
		!wb_err_o)
		else $error("error response raised");
endmodule // core_interrupt_option_control

// ==== verification/event_sources.sv ====
// Partner model: pins, rollover and peripheral pending seen by the block.
// Assumes bench requests change right after rising clock edges.
`timescale 1ns/1ps
module event_sources (
	// Clock, reset and bench requests
	input  wire logic       clock,
	input  wire logic       rstn,
	input  wire logic [8:0] req,
	// Registered pin, rollover, port and pending lines
	output logic      [8:0] lines_r
);
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			lines_r <= 9'h0;
		else
			lines_r <= req;
	end
endmodule // event_sources

// ==== verification/tb.sv ====
// Bench: random and corner stimulus for the interrupt and option block.
// Assumes one 20 MHz clock and the event_sources partner model.
`timescale 1ns/1ps
module tb import intctl_pkg::*;;
	logic        clock = 0, rstn = 0, cyc = 0, stb = 0, we = 0, ack, tick, wdt, irq, en = 1, err;
	logic [3:0]  adr = 4'h0;
	logic [31:0] wd = 32'h0, rd, dat;
	logic [5:0]  lat = 6'h0, pu, ioc = 6'h3f;
	logic [8:0]  rq = 9'h0, ln, div;
	logic [7:0]  v;
	int          mismatches = 0, n_tests = 0, seed = 88, i, c;
	initial forever #25 clock = ~clock;
	event_sources u_event_sources (.clock(clock), .rstn(rstn), .req(rq), .lines_r(ln));
	core_interrupt_option_control u_core_interrupt_option_control (.clock(clock), .rstn(rstn), .clk_en(en),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wd),
		.wb_dat_o(dat), .wb_ack_o(ack), .wb_err_o(err), .ext_irq_pin(ln[8]), .tmr_ext_clk_pin(ln[8]),
		.port_a_a(ln[6:1]), .pin_change_enable_reg(ioc), .pullup_latch(lat), .tmr_rollover(ln[7]),
		.periph_pending(ln[0]), .pullup_en(pu), .tmr_tick(tick), .prescaler_to_wdt(wdt), .prescale_div(div), .core_irq(irq));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		mismatches += (s !== e);
		if (s !== e)
			$display("unexpected %s expected %h seen %h", nm, e, s);
	endtask
	task automatic report_and_stop;
		$display("mismatches %0d n_tests %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		int k = 0;
		@(posedge clock);
		{cyc, stb, we, adr, wd} <= {2'b11, w, a, 24'h0, d};
		do
			@(posedge clock);
		while (ack !== 1'b1 && ++k < 20);
		mismatches += (k >= 20);
		if (k >= 20)
			report_and_stop;
		rd = dat;
		{cyc, stb} <= 2'b00;
	endtask
	function automatic logic exp_irq(input logic [7:0] e, input logic p);
		return e[7] & (e[5] & e[2] | e[4] & e[1] | e[3] & e[0] | e[6] & p);
	endfunction
	initial
	begin
		repeat (16) @(posedge clock);
		rstn <= 1'b1;
		bus(0, ADDR_OPTION, 8'h0);
		chk("option", 8'hff, rd);
		for (i = 0; i < 16; i++)
		begin
			lat <= 6'($random(seed));
			v = {i[0], 3'b100, i[3:0]};
			bus(1, ADDR_OPTION, v);
			chk("div", v[3] ? 9'h1 << v[2:0] : 9'h2 << v[2:0], div);
			chk("wdt", v[3], wdt);
			chk("pullup", v[7] ? 6'h0 : lat, pu);
			chk("tick", 1'b1, tick);
		end
		for (i = 0; i < 8; i++)
		begin
			bus(1, ADDR_OPTION, {1'b1, i[2], 1'b1, i[2], 4'hf});
			bus(1, ADDR_INTCTL, 8'h0);
			rq[8] <= ~rq[8];
			c = 0;
			repeat (5) @(posedge clock) c += tick;
			bus(0, ADDR_INTCTL, 8'h0);
			chk("ext_flag", rq[8] == i[2], rd[1]);
			chk("ticks", rq[8] != i[2], c);
		end
		bus(1, ADDR_INTCTL, 8'h0);
		rq <= rq ^ 9'h0c0;
		@(posedge clock);
		rq[7] <= 1'b0;
		bus(0, ADDR_INTCTL, 8'h0);
		chk("flags", 8'h05, rd);
		bus(1, ADDR_INTCTL, 8'h0);
		{en, ioc} <= 7'h00;
		rq <= rq ^ 9'h0c2;
		@(posedge clock);
		rq[7] <= 1'b0;
		repeat (3) @(posedge clock);
		en <= 1'b1;
		bus(0, ADDR_INTCTL, 8'h0);
		chk("frozen_masked", 8'h00, rd);
		ioc <= 6'h3f;
		for (i = 0; i < 40; i++)
		begin
			v = 8'($random(seed));
			rq[0] <= 1'($random(seed));
			bus(1, ADDR_INTCTL, v);
			bus(0, ADDR_INTCTL, 8'h0);
			chk("intctl", v, rd);
			chk("irq", exp_irq(v, ln[0]), irq);
		end
		bus(0, ADDR_STATUS, 8'h0);
		chk("status", 32'(exp_irq(v, ln[0])), rd);
		bus(0, 4'hc, 8'h0);
		chk("unmapped", 32'h0, rd);
		chk("err", 1'b0, err);
		rq <= 9'h0;
		repeat (3) @(posedge clock);
		rstn <= 1'b0;
		@(posedge clock);
		chk("irq_rst", 1'b0, irq);
		chk("div_rst", 9'h080, div);
		rstn <= 1'b1;
		bus(0, ADDR_OPTION, 8'h0);
		chk("option_rst", 8'hff, rd);
		bus(0, ADDR_INTCTL, 8'h0);
		chk("intctl_rst", 8'h00, rd);
		report_and_stop;
	end
endmodule // tb
